/* File: txfl_pkg.sv */
// Constants, register map and types for the transmit FIFO, loopback and statistics block
//
// Functional notes
// - FIFO is eight entries of four bytes
// - 16-bit writes fill one half, 32-bit whole
// - Drain starts only when count exceeds threshold or packet end fetched
// - Request DMA while count at or below threshold
// - Block mode moves threshold bytes; fill mode fills
// - Four read pointers chosen by byte order
// - Filler bytes dropped, only packet bytes leave
// - Packet data may start at any byte
// - Status and control registers are sixteen bits
// - Three loopback modes via two-bit field
// - Looped frames go to receive path normally
// - MAC loopback: encoder idle, collisions ignored
// - Internal encoder loopback: nothing off chip; any encoder loopback: collisions ignored
// - External encoder loopback drives loopback output
// - Transceiver echo only monitored in transceiver loopback
// - Unmatched source address sets monitored-bad flag
// - Loopback ends on receive or reject; status reported (here the loopback field stays set until rewritten)
// - Three tallies: CRC, alignment, missed packets
// - Frame end posts collisions and control to descriptors
// - Burst mode select picks block or fill
package txfl_pkg;

  localparam int TXFL_DEPTH = 8;
  localparam int TXFL_LANES = 4;
  localparam int TXFL_REG_W = 16;

  localparam logic [7:0] OFS_CFG     = 8'h00;
  localparam logic [7:0] OFS_RCR     = 8'h04;
  localparam logic [7:0] OFS_TCR     = 8'h08;
  localparam logic [7:0] OFS_CMD     = 8'h0C;
  localparam logic [7:0] OFS_FIFO    = 8'h10;
  localparam logic [7:0] OFS_CRC_ERROR_TALLY    = 8'h14;
  localparam logic [7:0] OFS_ALNT    = 8'h18;
  localparam logic [7:0] OFS_MISST   = 8'h1C;
  localparam logic [7:0] OFS_TXDESC  = 8'h20;
  localparam logic [7:0] OFS_RXDESC  = 8'h24;

  localparam int CFG_DW32    = 0;
  localparam int CFG_BIG     = 1;
  localparam int CFG_BMS     = 2;
  localparam int CFG_EXTENC  = 3;
  localparam int CFG_THR_LO  = 8;
  localparam int CFG_THR_W   = 5;
  localparam int RCR_LB_LO   = 9;
  localparam int RCR_STAT_W  = 9;
  localparam int TCR_STAT_W  = 11;
  localparam int TCR_PMB     = 11;
  localparam int CMD_GO      = 0;
  localparam int CMD_RXON    = 1;
  localparam int NC_W        = 5;

  localparam logic [15:0] CFG_RST = 16'h0800;
  localparam logic [15:0] RCR_RST = 16'h0000;
  localparam logic [15:0] TCR_RST = 16'h0000;
  localparam logic [15:0] CFG_WMASK = 16'h1F0F;
  localparam logic [15:0] RCR_WMASK = 16'hFE00;
  localparam logic [15:0] TCR_WMASK = 16'hF000;

  typedef enum logic [1:0] {
    LB_NONE = 2'b00,
    LB_MAC  = 2'b01,
    LB_ENC  = 2'b10,
    LB_XCVR = 2'b11
  } txfl_lb_e;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_WAIT = 2'b01,
    RD_RUN  = 2'b11
  } txfl_rd_e;

endpackage : txfl_pkg

/* File: txfl_top.sv */
// Transmit FIFO with byte-ordering reader, loopback routing and statistics registers
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module txfl_top
  import txfl_pkg::*;
#(
  parameter int DEPTH = TXFL_DEPTH
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             dma_req,
  input  wire logic        dma_grant,
  output logic             dma_burst,
  input  wire logic        dma_wvalid,
  input  wire logic [31:0] dma_wdata,
  input  wire logic [3:0]  dma_byte_en,
  input  wire logic        dma_upper,
  input  wire logic        dma_eop,
  output logic      [7:0]  ser_data,
  output logic             ser_valid,
  input  wire logic        ser_ready,
  output logic      [7:0]  lb_data,
  output logic             lb_valid,
  input  wire logic        rx_ready,
  input  wire logic [7:0]  echo_data,
  input  wire logic        echo_valid,
  output logic             line_tx_en,
  output logic             loopback_out,
  input  wire logic        collision_inputs,
  output logic             collision_seen,
  input  wire logic        sa_check,
  input  wire logic        sa_match,
  input  wire logic        tx_done,
  input  wire logic [4:0]  collision_count,
  input  wire logic [10:0] tx_status,
  input  wire logic        rx_done,
  input  wire logic [8:0]  rx_status,
  input  wire logic        crc_err,
  input  wire logic        align_err,
  input  wire logic        missed_pkt,
  output logic             receiver_on
);

  localparam int PW  = $clog2(DEPTH);
  localparam int CAP = DEPTH * TXFL_LANES;
  localparam logic [6:0] CAP_B = 7'(CAP);
  localparam logic [6:0] THR_MAX = 7'(CAP / 2);

  // The byte count is seven bits, so deeper arrays would wrap it
  if (DEPTH < 2 || DEPTH > 16 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_depth_chk
    $error("DEPTH must be a power of two from 2 to 16");
  end

  function automatic logic [15:0] tally_next(input logic [15:0] cur, input logic evt, input logic clr);
    // An event in the clearing cycle is counted, not lost
    tally_next = clr ? {15'h0000, evt} : (cur + {15'h0000, evt});
  endfunction : tally_next

  // eight four-byte entries with a per-byte valid mask
  logic [31:0]   mem_data [DEPTH];
  logic [3:0]    mem_ben  [DEPTH];
  logic          mem_eop  [DEPTH];

  logic [15:0]   cfg_reg, rx_control_reg, tx_control_reg, tx_desc_reg, rx_desc_reg;
  logic [15:0]   crc_error_tally, alignment_error_tally, missed_packet_tally;
  logic [PW:0]   wr_ptr_reg, rd_ptr_reg;
  logic [1:0]    lane_reg;
  logic          half_reg;
  logic [6:0]    byte_cnt_reg, burst_left_reg;
  logic          tx_active_reg, eop_fetched_reg;
  txfl_rd_e      rd_state_reg, rd_state_next;

  // APB decode
  wire           setup    = psel & ~penable;
  wire           wr_acc   = psel & penable & pwrite & pready;
  wire           hit_cfg  = paddr == OFS_CFG;
  wire           hit_rcr  = paddr == OFS_RCR;
  wire           hit_tcr  = paddr == OFS_TCR;
  wire           hit_cmd  = paddr == OFS_CMD;
  wire           hit_crc  = paddr == OFS_CRC_ERROR_TALLY;
  wire           hit_aln  = paddr == OFS_ALNT;
  wire           hit_mis  = paddr == OFS_MISST;
  wire           mapped   = hit_cfg | hit_rcr | hit_tcr | hit_cmd | hit_crc | hit_aln | hit_mis
                            | paddr == OFS_FIFO | paddr == OFS_TXDESC | paddr == OFS_RXDESC;
  wire           go_cmd   = wr_acc & hit_cmd & pwdata[CMD_GO];

  // Configuration fields; threshold clamped so a block burst always fits
  wire           dw32     = cfg_reg[CFG_DW32];
  wire           big_end  = cfg_reg[CFG_BIG];
  wire           burst_mode_select      = cfg_reg[CFG_BMS];
  wire           ext_enc  = cfg_reg[CFG_EXTENC];
  wire [6:0]     thr_raw  = {2'b00, cfg_reg[CFG_THR_LO +: CFG_THR_W]};
  wire [6:0]     thr      = (thr_raw > THR_MAX) ? THR_MAX : thr_raw;
  wire [1:0]     loopback_select = rx_control_reg[RCR_LB_LO +: 2];
  wire           lb_mac   = loopback_select == LB_MAC;
  wire           lb_enc   = loopback_select == LB_ENC;
  wire           lb_xcvr  = loopback_select == LB_XCVR;

  // Buffer engine write side
  wire           wr_acc_d = dma_burst & dma_wvalid;
  wire           half_cmp = big_end ? ~dma_upper : dma_upper;
  wire           ent_done = wr_acc_d & (dw32 | half_cmp);
  wire [6:0]     wr_bytes = wr_acc_d ? (dw32 ? 7'd4 : 7'd2) : 7'd0;
  wire [PW-1:0]  wr_idx   = wr_ptr_reg[PW-1:0];
  wire [3:0]     half_ben = dma_upper ? {dma_byte_en[3:2], 2'b00} : {2'b00, dma_byte_en[1:0]};
  wire [3:0]     ben_in   = dw32 ? dma_byte_en : half_ben;
  wire [PW:0]    full_ent = wr_ptr_reg - rd_ptr_reg;

  // Byte-ordering reader
  wire           sink_rdy = lb_mac ? rx_ready : ser_ready;
  wire           out_busy = lb_mac ? lb_valid : ser_valid;
  wire [PW-1:0]  rd_idx   = rd_ptr_reg[PW-1:0];
  wire [1:0]     rd_lane  = big_end ? ~lane_reg : lane_reg;
  wire           can_pop  = rd_state_reg == RD_RUN && full_ent != '0 && (!out_busy || sink_rdy);
  wire           pop_ok   = can_pop & mem_ben[rd_idx][rd_lane];
  wire [7:0]     pop_byte = mem_data[rd_idx][8 * rd_lane +: 8];
  wire           last_ln  = lane_reg == 2'd3;
  wire           pkt_end  = can_pop & last_ln & mem_eop[rd_idx];
  wire [6:0]     pop_cnt  = can_pop ? 7'd1 : 7'd0;
  wire [6:0]     byte_cnt_next = byte_cnt_reg + wr_bytes - pop_cnt;
  wire           thr_met  = byte_cnt_reg > thr;

  // Burst sizing
  wire [6:0]     burst_len = burst_mode_select ? thr : (CAP_B - byte_cnt_reg);
  wire           burst_end = wr_acc_d & (dma_eop | burst_left_reg <= wr_bytes);
  wire           dma_req_next = tx_active_reg & ~eop_fetched_reg & ~dma_burst & ~dma_grant
                                & ~dma_req & (byte_cnt_reg <= thr);

  always_comb
  begin
    rd_state_next = rd_state_reg;
    unique case (rd_state_reg)
      RD_IDLE: if (go_cmd) rd_state_next = RD_WAIT;
      RD_WAIT: if (thr_met || eop_fetched_reg) rd_state_next = RD_RUN;
      RD_RUN:  if (pkt_end) rd_state_next = RD_IDLE;
      default: rd_state_next = RD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_state_reg    <= RD_IDLE;
      wr_ptr_reg      <= '0;
      rd_ptr_reg      <= '0;
      lane_reg        <= 2'd0;
      half_reg        <= 1'b0;
      byte_cnt_reg    <= 7'd0;
      burst_left_reg  <= 7'd0;
      tx_active_reg   <= 1'b0;
      eop_fetched_reg <= 1'b0;
      dma_req         <= 1'b0;
      dma_burst       <= 1'b0;
    end
    else
    begin
      rd_state_reg <= rd_state_next;
      byte_cnt_reg <= byte_cnt_next;
      dma_req      <= dma_req_next;
      if (ent_done)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (wr_acc_d)
        half_reg <= ~ent_done;
      if (can_pop)
        lane_reg <= lane_reg + 2'd1;
      if (can_pop && last_ln)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (go_cmd)
        tx_active_reg <= 1'b1;
      else if (pkt_end)
        tx_active_reg <= 1'b0;
      if (go_cmd || pkt_end)
        eop_fetched_reg <= 1'b0;
      else if (wr_acc_d && dma_eop)
        eop_fetched_reg <= 1'b1;
      if (dma_grant && !dma_burst)
      begin
        dma_burst      <= 1'b1;
        burst_left_reg <= burst_len;
      end
      else if (burst_end)
        dma_burst <= 1'b0;
      else if (wr_acc_d)
        burst_left_reg <= burst_left_reg - wr_bytes;
    end
  end

  // byte enables mark where the packet begins within the word
  always_ff @(posedge pclk)
  begin
    if (wr_acc_d)
    begin
      if (dw32 || dma_upper)
        mem_data[wr_idx][31:16] <= dma_wdata[31:16];
      if (dw32 || !dma_upper)
        mem_data[wr_idx][15:0] <= dma_wdata[15:0];
      mem_ben[wr_idx] <= (dw32 || !half_reg) ? ben_in : (mem_ben[wr_idx] | ben_in);
      mem_eop[wr_idx] <= dma_eop;
    end
  end

  // Output stage and loopback routing; fillers pass no byte out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ser_data       <= 8'h00;
      ser_valid      <= 1'b0;
      lb_data        <= 8'h00;
      lb_valid       <= 1'b0;
      line_tx_en     <= 1'b0;
      loopback_out   <= 1'b0;
      collision_seen <= 1'b0;
    end
    else
    begin
      if (sink_rdy || !out_busy)
      begin
        ser_valid <= pop_ok & ~lb_mac;
        lb_valid  <= (pop_ok & lb_mac) | (echo_valid & lb_xcvr);
      end
      if (pop_ok && !lb_mac)
        ser_data <= pop_byte;
      if (pop_ok && lb_mac)
        lb_data <= pop_byte;
      else if (echo_valid && lb_xcvr)
        lb_data <= echo_data;
      line_tx_en     <= ~lb_mac & ~(lb_enc & ~ext_enc);
      loopback_out   <= lb_enc & ext_enc;
      collision_seen <= collision_inputs & ~lb_mac & ~lb_enc;
    end
  end

  // Registers, tallies and descriptor status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_reg               <= CFG_RST;
      rx_control_reg        <= RCR_RST;
      tx_control_reg        <= TCR_RST;
      tx_desc_reg           <= 16'h0000;
      rx_desc_reg           <= 16'h0000;
      crc_error_tally       <= 16'h0000;
      alignment_error_tally <= 16'h0000;
      missed_packet_tally   <= 16'h0000;
      receiver_on           <= 1'b0;
      prdata                <= 32'h0000_0000;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
    end
    else
    begin
      // Zero wait states: pready answers in the cycle after setup
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite)
      begin
        unique case (1'b1)
          hit_cfg:              prdata <= {16'h0000, cfg_reg};
          hit_rcr:              prdata <= {16'h0000, rx_control_reg};
          hit_tcr:              prdata <= {16'h0000, tx_control_reg};
          hit_cmd:              prdata <= {29'h0, dma_req, receiver_on, tx_active_reg};
          paddr == OFS_FIFO:    prdata <= {25'h0, byte_cnt_reg};
          hit_crc:              prdata <= {16'h0000, crc_error_tally};
          hit_aln:              prdata <= {16'h0000, alignment_error_tally};
          hit_mis:              prdata <= {16'h0000, missed_packet_tally};
          paddr == OFS_TXDESC:  prdata <= {16'h0000, tx_desc_reg};
          paddr == OFS_RXDESC:  prdata <= {16'h0000, rx_desc_reg};
          default:              prdata <= 32'h0000_0000;
        endcase
      end
      if (wr_acc && hit_cfg)
        cfg_reg <= pwdata[15:0] & CFG_WMASK;
      if (wr_acc && hit_rcr)
        rx_control_reg[15:RCR_STAT_W] <= pwdata[15:RCR_STAT_W];
      if (rx_done)
        rx_control_reg[RCR_STAT_W-1:0] <= rx_status;
      if (wr_acc && hit_tcr)
        tx_control_reg[15:12] <= pwdata[15:12];
      if (tx_done)
        tx_control_reg[TCR_STAT_W-1:0] <= tx_status;
      if (sa_check && !sa_match)
        tx_control_reg[TCR_PMB] <= 1'b1;
      else if (go_cmd)
        tx_control_reg[TCR_PMB] <= 1'b0;
      if (wr_acc && hit_cmd && pwdata[CMD_RXON])
        receiver_on <= 1'b1;
      if (tx_done)
        tx_desc_reg <= {collision_count, tx_control_reg[TCR_PMB], tx_status[9:0]};
      if (rx_done)
        rx_desc_reg <= {rx_control_reg[15:RCR_STAT_W], rx_status};
      crc_error_tally       <= tally_next(crc_error_tally, crc_err, wr_acc & hit_crc);
      alignment_error_tally <= tally_next(alignment_error_tally, align_err, wr_acc & hit_aln);
      missed_packet_tally   <= tally_next(missed_packet_tally, missed_pkt, wr_acc & hit_mis);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  fifo_bound_a: assert property (byte_cnt_reg <= CAP_B)
    else $error("transmit FIFO byte count above capacity");
  drain_start_a: assert property (rd_state_reg == RD_WAIT && rd_state_next == RD_RUN |->
    byte_cnt_reg > thr || eop_fetched_reg)
    else $error("reader started below threshold");
  dma_req_a: assert property ($rose(dma_req) |-> $past(byte_cnt_reg) <= $past(thr))
    else $error("DMA request raised above threshold");
  burst_len_a: assert property (dma_grant && !dma_burst && burst_mode_select |=> burst_left_reg == $past(thr))
    else $error("block burst not sized to threshold");
  ext_loop_a: assert property (lb_enc && ext_enc |=> loopback_out)
    else $error("loopback output missing in external encoder loopback");
  mac_quiet_a: assert property (lb_mac && $past(lb_mac) |-> !$rose(ser_valid) && !line_tx_en)
    else $error("encoder driven during MAC loopback");
  echo_drop_a: assert property (echo_valid && lb_valid && !$past(pop_ok) |-> lb_xcvr || lb_mac)
    else $error("echo buffered outside loopback");
  tally_inc_a: assert property (crc_err && !(wr_acc && hit_crc) |=>
    crc_error_tally == $past(crc_error_tally) + 16'h0001)
    else $error("CRC tally did not count");
  desc_post_a: assert property (tx_done |=> tx_desc_reg[15:11] == $past(collision_count))
    else $error("collision count not posted");
  pmb_set_a: assert property (sa_check && !sa_match |=> tx_control_reg[TCR_PMB])
    else $error("monitored-bad flag not set");
  filler_drop_a: assert property (can_pop && !pop_ok && !lb_mac |=> !ser_valid)
    else $error("filler byte reached the serializer");

  cov_block_burst: cover property (dma_grant && burst_mode_select ##[1:20] !dma_burst);
  cov_mac_loop:    cover property (lb_mac && lb_valid ##1 pkt_end);
  cov_filler:      cover property (can_pop && !pop_ok);
  cov_half_write:  cover property (wr_acc_d && !dw32 ##1 wr_acc_d);
  cov_echo_loop:   cover property (echo_valid && lb_xcvr ##1 lb_valid);

endmodule : txfl_top

/* File: txfl_mem_model.sv */
// Memory-side partner: answers fetch requests and streams packet words
`timescale 1ns/10ps
module txfl_mem_model
  import txfl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        rewind,
  input  wire logic        mode16,
  input  wire logic        hi_first,
  input  wire logic [7:0]  gap,
  input  wire logic        dma_req,
  output logic             dma_grant,
  input  wire logic        dma_burst,
  output logic             dma_wvalid,
  output logic      [31:0] dma_wdata,
  output logic      [3:0]  dma_byte_en,
  output logic             dma_upper,
  output logic             dma_eop,
  output logic      [3:0]  grants
);
  logic [31:0] words [0:7];
  logic [3:0]  ens   [0:7];
  int          n_words;
  int          idx;
  logic        pend;
  logic [7:0]  wait_cnt;
  logic [31:0] last_d;
  logic        hsel;

  // Released data shows the inverse of the last word, never a stale copy
  assign dma_wvalid  = dma_burst && (idx < n_words);
  assign dma_wdata   = dma_wvalid ? words[idx] : ~last_d;
  assign dma_byte_en = dma_wvalid ? ens[idx] : 4'h0;
  // In 16-bit mode each word goes as two halves; the second one closes the entry
  assign dma_eop     = dma_wvalid && (idx == n_words - 1) && (!mode16 || hsel);
  assign dma_upper   = mode16 & (hsel ^ hi_first);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn || rewind)
    begin
      dma_grant <= 1'b0;
      pend      <= 1'b0;
      wait_cnt  <= 8'h00;
      grants    <= 4'h0;
      idx       <= 0;
      last_d    <= 32'h0000_0000;
      hsel      <= 1'b0;
    end
    else
    begin
      dma_grant <= 1'b0;
      // Grant latency is set by the bench so both prompt and slow memory are seen
      // A request that overlaps a grant or a burst is the same fetch, not a new one
      if (dma_req && !pend && !dma_grant && !dma_burst)
      begin
        pend     <= 1'b1;
        wait_cnt <= gap;
      end
      else if (pend && wait_cnt == 8'h00)
      begin
        dma_grant <= 1'b1;
        pend      <= 1'b0;
        grants    <= grants + 4'h1;
      end
      else if (pend)
        wait_cnt <= wait_cnt - 8'h01;
      if (dma_burst && dma_wvalid)
      begin
        hsel   <= mode16 & ~hsel;
        last_d <= dma_wdata;
        if (!mode16 || hsel)
          idx <= idx + 1;
      end
    end
  end
endmodule : txfl_mem_model

/* File: tb.sv */
// Self-checking testbench for the transmit FIFO block
`timescale 1ns/10ps
module tb
  import txfl_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, dma_wdata, q;
  logic pready, pslverr, dma_req, dma_grant, dma_burst, dma_wvalid, dma_upper, dma_eop, err;
  logic [3:0] dma_byte_en, grants;
  logic [7:0] ser_data, lb_data, gap = 8'h00, echo_data = 8'h00;
  logic ser_valid, lb_valid, line_tx_en, loopback_out, collision_seen, receiver_on;
  logic ser_ready = 0, rx_ready = 0, echo_valid = 0, collision_inputs = 0, rewind = 0;
  logic mode16 = 0, hi_first = 0;
  logic sa_check = 0, sa_match = 0, tx_done = 0, rx_done = 0, crc_err = 0, align_err = 0, missed_pkt = 0;
  logic [4:0] collision_count = 5'h00;
  logic [10:0] tx_status = 11'h000;
  logic [8:0] rx_status = 9'h000;
  int fail_count = 0, n_compared = 0;

  always #20 pclk = ~pclk;

  txfl_top txfl_top_inst (.*);
  txfl_mem_model txfl_mem_model_inst (.pclk(pclk), .presetn(presetn), .rewind(rewind), .gap(gap),
    .mode16(mode16), .hi_first(hi_first),
    .dma_req(dma_req), .dma_grant(dma_grant), .dma_burst(dma_burst), .dma_wvalid(dma_wvalid),
    .dma_wdata(dma_wdata), .dma_byte_en(dma_byte_en), .dma_upper(dma_upper), .dma_eop(dma_eop),
    .grants(grants));

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task results;
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task t_reset_map;
    apb(0, OFS_CFG, 0);  chk("cfg reset", 32'h0000_0800, q);
    apb(0, OFS_RCR, 0);  chk("rcr reset", 32'h0, q);
    apb(0, 8'h3C, 0);    chk("unmapped err", 1, err);
    chk("unmapped data", 0, q);
  endtask : t_reset_map

  // Packet of byte k = 30h+k; little endian opens with a filler in lane 0
  task t_packet(input logic big, input logic blk, input logic w16, input logic mac);
    int nb;
    logic [7:0] b [0:11];
    for (int k = 0; k < 12; k++) b[k] = 8'h30 + k[7:0];
    nb = big ? 12 : 11;
    for (int w = 0; w < 3; w++)
    begin
      txfl_mem_model_inst.ens[w] = (!big && w == 0) ? 4'hE : 4'hF;
      txfl_mem_model_inst.words[w] = big ? {b[4*w], b[4*w+1], b[4*w+2], b[4*w+3]} :
        (w == 0) ? {b[2], b[1], b[0], 8'hEE} : {b[4*w+2], b[4*w+1], b[4*w], b[4*w-1]};
    end
    txfl_mem_model_inst.n_words = 3;
    gap <= blk ? 8'd20 : 8'd0;
    mode16 <= w16;
    hi_first <= big;
    ser_ready <= 0;
    rx_ready <= 0;
    rewind <= 1;
    @(posedge pclk) rewind <= 0;
    apb(1, OFS_CFG, {16'h0, 3'b000, 5'd8, 5'b0, blk, big, ~w16});
    apb(1, OFS_RCR, {22'h0, mac, 9'h000});
    apb(1, OFS_CMD, 32'h3);
    while (txfl_mem_model_inst.idx < 2) @(posedge pclk);
    repeat (3) @(posedge pclk);
    if (blk) chk("early drain", 0, ser_valid);
    while (txfl_mem_model_inst.idx < 3) @(posedge pclk);
    repeat (4) @(posedge pclk);
    chk("grant count", blk ? 2 : 1, grants);
    chk("burst idle", 0, dma_burst);
    chk("req idle", 0, dma_req);
    chk("rx on", 1, receiver_on);
    ser_ready <= 1;
    rx_ready <= 1;
    for (int k = 0; k < nb; k++)
    begin
      do @(posedge pclk); while ((mac ? lb_valid : ser_valid) !== 1'b1);
      chk("out byte", b[k], mac ? lb_data : ser_data);
    end
    @(posedge pclk);
    chk("extra byte", 0, mac ? lb_valid : ser_valid);
  endtask : t_packet

  task t_loopback;
    apb(1, OFS_CFG, 32'h0000_0809);
    for (int m = 0; m < 4; m++)
    begin
      apb(1, OFS_RCR, m << RCR_LB_LO);
      collision_inputs <= 1;
      echo_valid <= 1;
      echo_data <= 8'hA0 + m[7:0];
      repeat (3) @(posedge pclk);
      chk("coll seen", (m == LB_NONE || m == LB_XCVR), collision_seen);
      chk("lb out", m == LB_ENC, loopback_out);
      chk("line en", m != LB_MAC, line_tx_en);
      chk("echo kept", m == LB_XCVR, lb_valid);
      if (m == LB_XCVR) chk("echo data", 8'hA0 + m[7:0], lb_data);
      collision_inputs <= 0;
      echo_valid <= 0;
      apb(0, OFS_RCR, 0);
      chk("lb field", m, q[10:9]);
    end
    apb(1, OFS_RCR, 0);
    apb(1, OFS_CFG, 32'h0000_0801);
    apb(1, OFS_RCR, 32'h0000_0400);
    repeat (2) @(posedge pclk);
    chk("int enc line", 0, line_tx_en);
    chk("int enc lbk", 0, loopback_out);
    apb(1, OFS_RCR, 0);
  endtask : t_loopback

  task t_status;
    @(posedge pclk) begin sa_check <= 1; sa_match <= 0; end
    @(posedge pclk) sa_check <= 0;
    apb(0, OFS_TCR, 0); chk("pmb", 1, q[TCR_PMB]);
    @(posedge pclk) begin tx_done <= 1; collision_count <= 5'h13; tx_status <= 11'h2A5; end
    @(posedge pclk) tx_done <= 0;
    apb(0, OFS_TXDESC, 0); chk("tx desc", {16'h0, 5'h13, 1'b1, 10'h2A5}, q);
    @(posedge pclk) begin rx_done <= 1; rx_status <= 9'h155; end
    @(posedge pclk) rx_done <= 0;
    apb(0, OFS_RXDESC, 0); chk("rx desc", 32'h0000_0155, q);
    apb(0, OFS_RCR, 0);    chk("rx status", 32'h0000_0155, q);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge pclk) begin crc_err <= 1; align_err <= (i == 0); missed_pkt <= (i == 1); end
      @(posedge pclk) begin crc_err <= 0; align_err <= 0; missed_pkt <= 0; end
    end
    apb(0, OFS_CRC_ERROR_TALLY, 0);  chk("crc tally", 2, q);
    apb(0, OFS_ALNT, 0);  chk("align tally", 1, q);
    apb(0, OFS_MISST, 0); chk("miss tally", 1, q);
    apb(1, OFS_CRC_ERROR_TALLY, 0);
    apb(0, OFS_CRC_ERROR_TALLY, 0);  chk("crc clear", 0, q);
  endtask : t_status

  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    results();
  end

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reset_map();
    t_packet(0, 1, 1, 0);
    t_packet(1, 0, 0, 0);
    t_packet(0, 0, 0, 1);
    t_loopback();
    t_status();
    results();
  end
endmodule : tb
